/* hsfm_top.sv */
// Fault qualification and restart sequencing of the hot swap controller
`timescale 1ns/1ps
module hsfm_top #(
    parameter int VFILT_CYC   = hsfm_pkg::VFILT_CYC,
    parameter int STARTUP_CYC = hsfm_pkg::STARTUP_CYC,
    parameter int PG_CYC      = hsfm_pkg::PG_CYC
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // Comparator and sensor levels, asynchronous
    input  wire logic low_voltage_sense_in,
    input  wire logic high_voltage_sense_in,
    input  wire logic over_temp_in,
    input  wire logic temp_cool_in,
    input  wire logic enable_in,
    // Charging sequencer, same clock
    input  wire logic charge_done_in,
    // Power path control
    output logic      pass_switch_on_out,
    output logic      charge_en_out,
    output logic      power_good_out,
    output logic      power_good_b_out,
    output logic      retry_stop_out
);
    logic [hsfm_pkg::NSYNC-1:0] sync1_reg;
    logic [hsfm_pkg::NSYNC-1:0] sync2_reg;
    logic [hsfm_pkg::NSYNC-1:0] raw_in;

    assign raw_in = {enable_in, temp_cool_in, over_temp_in,
                     high_voltage_sense_in, low_voltage_sense_in};

    // Two-flop synchronisers, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < hsfm_pkg::NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end
                else
                begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic low_q;
    logic high_q;
    logic hot_q;

    hsfm_filter #(.LIMIT(VFILT_CYC), .CNT_W(hsfm_pkg::TIMER_W)) u_low_filt (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .cond_in  (sync2_reg[hsfm_pkg::SY_LOW]),
        .qual_out (low_q)
    );

    hsfm_filter #(.LIMIT(VFILT_CYC), .CNT_W(hsfm_pkg::TIMER_W)) u_high_filt (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .cond_in  (sync2_reg[hsfm_pkg::SY_HIGH]),
        .qual_out (high_q)
    );

    hsfm_filter #(.LIMIT(hsfm_pkg::TFILT_CYC),
                  .CNT_W(hsfm_pkg::TIMER_W)) u_hot_filt (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .cond_in  (sync2_reg[hsfm_pkg::SY_HOT]),
        .qual_out (hot_q)
    );

    hsfm_pkg::hsfm_state_t         state_reg;
    hsfm_pkg::hsfm_state_t         state_next;
    logic [hsfm_pkg::TIMER_W-1:0]  timer_reg;
    logic [hsfm_pkg::TIMER_W-1:0]  timer_next;
    logic [hsfm_pkg::RETRY_W-1:0]  retry_reg;
    logic [hsfm_pkg::RETRY_W-1:0]  retry_next;
    logic                          ot_reg;
    logic                          ot_next;
    logic                          ok_prev_reg;
    logic                          start_ok;
    logic                          abort;
    logic                          pass_next;
    logic                          chg_next;
    logic                          pg_next;
    logic                          stop_next;

    always_comb
    begin
        // Thermal latch holds until the cool indication arrives
        ot_next = ot_reg;
        if (hot_q)
        begin
            ot_next = 1'b1;
        end
        else if (sync2_reg[hsfm_pkg::SY_COOL])
        begin
            ot_next = 1'b0;
        end
        start_ok = !low_q && !high_q && !ot_reg &&
                   sync2_reg[hsfm_pkg::SY_EN];
        abort = ok_prev_reg && !start_ok &&
                (ot_reg || !sync2_reg[hsfm_pkg::SY_EN]);

        retry_next = retry_reg;
        if (abort && retry_reg <= hsfm_pkg::RETRY_MAX)
        begin
            retry_next = retry_reg + 4'h1;
        end

        state_next = state_reg;
        timer_next = hsfm_pkg::TIMER_RESET;
        if (!start_ok)
        begin
            state_next = hsfm_pkg::HSFM_WAIT;
        end
        else
        begin
            case (state_reg)
                hsfm_pkg::HSFM_WAIT:
                begin
                    if (timer_reg ==
                        hsfm_pkg::TIMER_W'(STARTUP_CYC - 1))
                    begin
                        if (retry_reg <= hsfm_pkg::RETRY_MAX)
                        begin
                            state_next = hsfm_pkg::HSFM_CHARGE;
                        end
                        else
                        begin
                            timer_next = timer_reg;
                        end
                    end
                    else
                    begin
                        timer_next = timer_reg + 32'h1;
                    end
                end
                hsfm_pkg::HSFM_CHARGE:
                begin
                    if (charge_done_in)
                    begin
                        state_next = hsfm_pkg::HSFM_PGDLY;
                    end
                end
                hsfm_pkg::HSFM_PGDLY:
                begin
                    if (timer_reg == hsfm_pkg::TIMER_W'(PG_CYC - 1))
                    begin
                        state_next = hsfm_pkg::HSFM_ON;
                        retry_next = hsfm_pkg::RETRY_RESET;
                    end
                    else
                    begin
                        timer_next = timer_reg + 32'h1;
                    end
                end
                hsfm_pkg::HSFM_ON:
                begin
                    state_next = hsfm_pkg::HSFM_ON;
                end
                default:
                begin
                    state_next = hsfm_pkg::HSFM_WAIT;
                end
            endcase
        end

        pass_next = (state_next != hsfm_pkg::HSFM_WAIT);
        chg_next  = (state_next == hsfm_pkg::HSFM_CHARGE);
        pg_next   = (state_next == hsfm_pkg::HSFM_ON);
        stop_next = (retry_next > hsfm_pkg::RETRY_MAX);
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg          <= hsfm_pkg::HSFM_WAIT;
            timer_reg          <= hsfm_pkg::TIMER_RESET;
            retry_reg          <= hsfm_pkg::RETRY_RESET;
            ot_reg             <= 1'b0;
            ok_prev_reg        <= 1'b0;
            pass_switch_on_out <= 1'b0;
            charge_en_out      <= 1'b0;
            power_good_out     <= 1'b0;
            power_good_b_out   <= 1'b1;
            retry_stop_out     <= 1'b0;
        end
        else
        begin
            state_reg          <= state_next;
            timer_reg          <= timer_next;
            retry_reg          <= retry_next;
            ot_reg             <= ot_next;
            ok_prev_reg        <= start_ok;
            pass_switch_on_out <= pass_next;
            charge_en_out      <= chg_next;
            power_good_out     <= pg_next;
            power_good_b_out   <= !pg_next;
            retry_stop_out     <= stop_next;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_FAULT_SWITCH_OFF: assert property (
        (low_q || high_q) |=> !pass_switch_on_out && !power_good_out
    ) else $error("switch not off after voltage fault");

    AST_HOT_SWITCH_OFF: assert property (
        ot_reg |=> !pass_switch_on_out && power_good_b_out
    ) else $error("switch not off after thermal fault");

    AST_PG_PAIR: assert property (
        power_good_out != power_good_b_out
    ) else $error("power-good outputs not complementary");

    AST_TIMER_RESTART: assert property (
        !start_ok |=> timer_reg == hsfm_pkg::TIMER_RESET
    ) else $error("start-up timer not restarted on fault");

    AST_FULL_TIMER: assert property (
        $rose(pass_switch_on_out) |->
            $past(timer_reg) == hsfm_pkg::TIMER_W'(STARTUP_CYC - 1)
    ) else $error("switch on before start-up timer expired");

    AST_PG_DELAY: assert property (
        $rose(power_good_out) |->
            $past(state_reg) == hsfm_pkg::HSFM_PGDLY &&
            $past(timer_reg) == hsfm_pkg::TIMER_W'(PG_CYC - 1) &&
            retry_reg == hsfm_pkg::RETRY_RESET
    ) else $error("power-good rose without full delay");

    AST_RETRY_STOP: assert property (
        (state_reg == hsfm_pkg::HSFM_WAIT &&
         retry_reg > hsfm_pkg::RETRY_MAX) |=> !pass_switch_on_out
    ) else $error("restart attempted beyond retry limit");

    AST_HOT_HOLD: assert property (
        (ot_reg && !hot_q && !sync2_reg[hsfm_pkg::SY_COOL]) |=> ot_reg
    ) else $error("thermal latch released before cooling");
endmodule

/* hsfm_pkg.sv */
// Shared constants of the hot swap fault monitor
package hsfm_pkg;
    // Clock rate and derived periods
    localparam int CLK_MHZ         = 250;
    localparam int CLK_PERIOD_NS   = 4;
    // Voltage filter time, 1.0 ms
    localparam int VFILT_TIME_US   = 1000;
    localparam int VFILT_CYC       = VFILT_TIME_US * CLK_MHZ;
    // Thermal filter time, 12 us, rounded up to whole cycles
    localparam int TFILT_TIME_NS   = 12000;
    localparam int TFILT_CYC       =
        (TFILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Start-up timer, default 200 ms
    localparam int STARTUP_TIME_MS = 200;
    localparam int STARTUP_CYC     = STARTUP_TIME_MS * 1000 * CLK_MHZ;
    // Power-good delay after charging, 20 ms
    localparam int PG_TIME_MS      = 20;
    localparam int PG_CYC          = PG_TIME_MS * 1000 * CLK_MHZ;
    // Retry limit and counter layout
    localparam int RETRY_W         = 4;
    localparam logic [RETRY_W-1:0] RETRY_MAX   = 4'ha;
    localparam logic [RETRY_W-1:0] RETRY_RESET = 4'h0;
    localparam int TIMER_W         = 32;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0;
    // Synchronised inputs
    localparam int NSYNC           = 5;
    localparam int SY_LOW          = 0;
    localparam int SY_HIGH         = 1;
    localparam int SY_HOT          = 2;
    localparam int SY_COOL         = 3;
    localparam int SY_EN           = 4;

    typedef enum logic [4:0] {
        HSFM_WAIT   = 5'h01,
        HSFM_CHARGE = 5'h02,
        HSFM_PGDLY  = 5'h04,
        HSFM_ON     = 5'h08,
        HSFM_SPARE  = 5'h10
    } hsfm_state_t;
endpackage

/* hsfm_filter.sv */
// Persistence filter: output follows input after it differs long enough
`timescale 1ns/1ps
module hsfm_filter #(
    parameter int LIMIT = 4,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // Condition in, qualified level out
    input  wire logic cond_in,
    output logic      qual_out
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             q_reg;
    logic             q_next;

    always_comb
    begin
        cnt_next = '0;
        q_next   = q_reg;
        // Count restarts whenever the input agrees with the output again
        if (cond_in != q_reg)
        begin
            if (cnt_reg == CNT_W'(LIMIT))
            begin
                q_next = cond_in;
            end
            else
            begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_reg <= '0;
            q_reg   <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            q_reg   <= q_next;
        end
    end

    assign qual_out = q_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_QUAL_TIME: assert property (
        (q_reg != $past(q_reg)) |-> ($past(cnt_reg) == CNT_W'(LIMIT))
    ) else $error("filter output changed before its time");
endmodule

/* hsfm_sense_model.sv */
// Behavioural comparators, die sensor and charging sequencer
`timescale 1ns/1ps
module hsfm_sense_model #(
    parameter int CHG_CYC = 6
) (
    // Clock
    input  wire logic clk_in,
    // Conditions commanded by the bench
    input  wire logic low_req_in,
    input  wire logic high_req_in,
    input  wire logic hot_req_in,
    input  wire logic cool_req_in,
    // Power path state
    input  wire logic pass_on_in,
    input  wire logic charge_en_in,
    // Levels towards the monitor
    output logic      low_voltage_sense_out,
    output logic      high_voltage_sense_out,
    output logic      over_temp_out,
    output logic      temp_cool_out,
    output logic      charge_done_out
);
    int chg_cnt;
    assign low_voltage_sense_out  = low_req_in;
    assign high_voltage_sense_out = high_req_in;
    assign over_temp_out          = hot_req_in;
    // A hot die never reports cool at the same time
    assign temp_cool_out          = cool_req_in & ~hot_req_in;
    assign charge_done_out        = (chg_cnt >= CHG_CYC);
    // Load charges only while the switch is on and charging runs
    always_ff @(posedge clk_in)
    begin
        if (!pass_on_in)
            chg_cnt <= 0;
        else if (charge_en_in && chg_cnt < CHG_CYC)
            chg_cnt <= chg_cnt + 1;
    end
endmodule

/* hot_swap_fault_monitor_bench.sv */
// Self-checking bench of the hot swap fault monitor
`timescale 1ns/1ps
module hot_swap_fault_monitor_bench;
    localparam int VF = 8;
    localparam int SU = 20;
    localparam int PG = 10;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic lo_r = 1'b0, hi_r = 1'b0, hot_r = 1'b0, cool_r = 1'b1;
    logic en = 1'b1;
    logic lvs, hvs, ot, tc, cd, sw, ce, pg, pg_b, rs;
    int   error_cnt = 0;
    int   n_tests = 0;

    always #2 clk_in = ~clk_in;

    hsfm_sense_model i_hsfm_sense_model (.clk_in(clk_in), .low_req_in(lo_r),
        .high_req_in(hi_r), .hot_req_in(hot_r), .cool_req_in(cool_r),
        .pass_on_in(sw), .charge_en_in(ce), .low_voltage_sense_out(lvs),
        .high_voltage_sense_out(hvs), .over_temp_out(ot),
        .temp_cool_out(tc), .charge_done_out(cd));

    hsfm_top #(.VFILT_CYC(VF), .STARTUP_CYC(SU), .PG_CYC(PG)) i_hsfm_top (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .low_voltage_sense_in(lvs),
        .high_voltage_sense_in(hvs), .over_temp_in(ot), .temp_cool_in(tc),
        .enable_in(en), .charge_done_in(cd), .pass_switch_on_out(sw),
        .charge_en_out(ce), .power_good_out(pg), .power_good_b_out(pg_b),
        .retry_stop_out(rs));

    task automatic check(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Waits for the switch to reach exp, inside the window lo..hi+1 cycles
    task automatic wait_sw(input string nm, input logic exp, input int lo,
                           input int hi);
        int n;
        n = 0;
        while (sw !== exp && n <= hi)
        begin
            cyc(1);
            n++;
        end
        check(nm, exp, sw);
        check({nm, "_early"}, 1'b1, logic'(n >= lo));
    endtask

    // Switch must hold exp for n cycles
    task automatic stay(input string nm, input logic exp, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n)
        begin
            cyc(1);
            if (sw !== exp)
                ok = 1'b0;
        end
        check(nm, 1'b1, ok);
    endtask

    task automatic power_up(input int lo, input int hi);
        int n;
        wait_sw("switch_on", 1'b1, lo, hi);
        check("charge_en", 1'b1, ce);
        check("pg_at_on", 1'b0, pg);
        n = 0;
        while (pg !== 1'b1 && n < PG + 30)
        begin
            cyc(1);
            n++;
        end
        check("power_good", 1'b1, pg);
        check("pg_delay", 1'b1, logic'(n >= PG));
        check("power_good_b", 1'b0, pg_b);
        check("charge_en_off", 1'b0, ce);
    endtask

    task automatic set_v(input bit sel, input logic v);
        if (sel)
            hi_r = v;
        else
            lo_r = v;
    endtask

    task automatic t_volt(input bit sel);
        set_v(sel, 1'b1);
        cyc(VF - 2);
        set_v(sel, 1'b0);
        stay("glitch_kept_on", 1'b1, 3 * VF);
        set_v(sel, 1'b1);
        wait_sw("fault_off", 1'b0, VF, VF + 8);
        check("fault_pg", 1'b0, pg);
        check("fault_pg_b", 1'b1, pg_b);
        cyc(VF);
        set_v(sel, 1'b0);
        stay("recover_wait", 1'b0, VF + 10);
        set_v(sel, 1'b1);
        cyc(VF + 4);
        set_v(sel, 1'b0);
        stay("refault_off", 1'b0, VF + SU);
        // Recovery filter plus full timer leave three cycles after the stay
        power_up(2, 4);
    endtask

    task automatic t_thermal;
        hot_r = 1'b1;
        stay("hot_glitch", 1'b1, 2000);
        hot_r = 1'b0;
        stay("hot_glitch_after", 1'b1, 3100);
        hot_r = 1'b1;
        cool_r = 1'b0;
        wait_sw("hot_off", 1'b0, 2990, 3020);
        check("hot_pg", 1'b0, pg);
        hot_r = 1'b0;
        stay("not_cool", 1'b0, 3200);
        cool_r = 1'b1;
        power_up(SU, SU + 4);
    endtask

    task automatic t_retry;
        en = 1'b0;
        wait_sw("disable_off", 1'b0, 0, 6);
        cyc(4);
        repeat (9)
        begin
            en = 1'b1;
            cyc(6);
            en = 1'b0;
            cyc(6);
        end
        check("retry_ten", 1'b0, rs);
        en = 1'b1;
        cyc(6);
        en = 1'b0;
        cyc(6);
        check("retry_stop", 1'b1, rs);
        en = 1'b1;
        stay("retry_no_start", 1'b0, SU + 20);
        // Reset in mid-run clears the retry counter and allows a start
        rst_b_in = 1'b0;
        cyc(3);
        check("reset_retry", 1'b0, rs);
        check("reset_mid_pg_b", 1'b1, pg_b);
        rst_b_in = 1'b1;
        power_up(SU, SU + 4);
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        stop_test();
    end

    initial
    begin
        cyc(20);
        check("reset_pg_b", 1'b1, pg_b);
        check("reset_sw", 1'b0, sw);
        rst_b_in = 1'b1;
        power_up(SU, SU + 4);
        t_volt(1'b0);
        t_volt(1'b1);
        t_thermal();
        t_retry();
        stop_test();
    end
endmodule
